// ==== design/pwmdt_core.sv ====
// PWM generator with dead-time, alignment, external reset and update control.
// Assumes a single 25 MHz clock, register strobes from logic on that clock,
// and current-limit and compensation inputs arriving from pins.
`timescale 1ns/1ps
`default_nettype none
`include "pwmdt_params.svh"

module pwmdt_core
    import pwmdt_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register port
    input wire logic [`PWMDT_ADDR_W-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // Pins
    input wire logic curr_limit_in,
    input wire logic compensation_input_in,
    output logic high_side_output_out,
    output logic low_side_output_out,
    output logic period_boundary_out
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic pwmdt_timing_t put_word(input pwmdt_timing_t cur,
                                               input logic [`PWMDT_ADDR_W-1:0] idx,
                                               input logic [15:0] val);
        pwmdt_timing_t res;
        res = cur;
        case (idx)
            `PWMDT_IDX_MDUTY: res.mdc = val;
            `PWMDT_IDX_GDUTY: res.pdc = val;
            `PWMDT_IDX_DT: res.dtr = val;
            `PWMDT_IDX_ALTDT: res.alt = val;
            `PWMDT_IDX_PHASE: res.phase = val;
            default: res = cur;
        endcase
        return res;
    endfunction : put_word

    function automatic logic is_timing(input logic [`PWMDT_ADDR_W-1:0] idx);
        return (idx >= `PWMDT_IDX_MDUTY) && (idx <= `PWMDT_IDX_PHASE);
    endfunction : is_timing

    // ****************************************
    // State
    // ****************************************
    pwmdt_ctrl_t ctrl;
    pwmdt_cfg_t cfg;
    logic [15:0] period_buf;
    logic [15:0] period_act;
    pwmdt_timing_t tim_buf;
    pwmdt_timing_t tim_act;
    logic [15:0] tb;
    pwmdt_dir_t dir;
    logic [1:0] cl_sync;
    logic [1:0] cmp_sync;
    logic cl_prev;
    logic raw_prev;
    logic [15:0] dly_cnt;

    // ****************************************
    // Decoding
    // ****************************************
    wire logic wr_ctrl = wr_in && (addr_in == `PWMDT_IDX_CTRL);
    wire logic wr_cfg = wr_in && (addr_in == `PWMDT_IDX_CFG);
    wire logic wr_period = wr_in && (addr_in == `PWMDT_IDX_PERIOD);
    wire logic wr_timing = wr_in && is_timing(addr_in);
    wire logic cl_s = cl_sync[1];
    wire logic cmp_s = cmp_sync[1];
    wire logic center = ctrl.alignment_select_bit && cfg.independent_time_base_option;
    wire logic ext_rst = ctrl.external_reset_control_bit && cfg.independent_time_base_option && cl_s && !cl_prev;
    wire logic boundary = center ? ((dir == PWMDT_DOWN) && (tb == 16'h0000))
                                 : (tb >= period_act);
    wire logic [15:0] duty = cfg.use_mdc ? tim_act.mdc : tim_act.pdc;
    wire logic raw = cfg.en && (tb < duty);
    wire logic rise = raw && !raw_prev;
    wire logic fall = !raw && raw_prev;
    wire logic dly_zero = (dly_cnt == 16'h0000);
    wire logic dly_done = dly_zero && !rise && !fall;
    wire logic comp_mode = (ctrl.dead_time_control_field == PWMDT_DT_COMP);
    wire logic shorten_high = comp_mode && !(ctrl.compensation_polarity_bit ^ cmp_s);
    wire logic [15:0] dly_load = (fall && !comp_mode) ? tim_act.alt : tim_act.dtr;
    wire logic [15:0] next_dly = (rise || fall) ? dly_load
                               : (dly_zero ? 16'h0000 : dly_cnt - 16'h0001);
    wire pwmdt_timing_t tim_written = put_word(tim_buf, addr_in, wdata_in);
    wire pwmdt_timing_t next_tim_act = (wr_timing && ctrl.immediate_update_bit)
                                     ? put_word(tim_act, addr_in, wdata_in)
                                     : (boundary ? tim_buf : tim_act);

    // ****************************************
    // Output shaping
    // ****************************************
    logic next_hi;
    logic next_lo;
    always_comb begin
        next_hi = 1'b0;
        next_lo = 1'b0;
        case (ctrl.dead_time_control_field)
            PWMDT_DT_POS: begin
                next_hi = raw && dly_done;
                next_lo = !raw && dly_done;
            end
            PWMDT_DT_NEG: begin
                next_hi = raw || !dly_done;
                next_lo = !raw || !dly_done;
            end
            PWMDT_DT_OFF: begin
                next_hi = raw;
                next_lo = !raw;
            end
            PWMDT_DT_COMP: begin
                if (shorten_high) begin
                    next_hi = raw && dly_done;
                    next_lo = !next_hi;
                end else begin
                    next_lo = !raw && dly_done;
                    next_hi = !next_lo;
                end
            end
            default: begin
                next_hi = 1'b0;
                next_lo = 1'b0;
            end
        endcase
        if (!cfg.en) begin
            next_hi = 1'b0;
            next_lo = 1'b0;
        end
    end

    // ****************************************
    // Time base
    // ****************************************
    logic [15:0] next_tb;
    pwmdt_dir_t next_dir;
    always_comb begin
        next_tb = tb + 16'h0001;
        next_dir = dir;
        if (!cfg.en || ext_rst) begin
            next_tb = 16'h0000;
            next_dir = PWMDT_UP;
        end else if (!center) begin
            if (boundary) begin
                next_tb = (tim_act.phase < period_act) ? tim_act.phase : 16'h0000;
            end
            next_dir = PWMDT_UP;
        end else if (dir == PWMDT_UP) begin
            if (tb >= period_act) begin
                next_dir = PWMDT_DOWN;
                next_tb = (tb == 16'h0000) ? 16'h0000 : tb - 16'h0001;
            end
        end else begin
            if (boundary) begin
                next_dir = PWMDT_UP;
            end else begin
                next_tb = tb - 16'h0001;
            end
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        case (addr_in)
            // bits 4 and 3 read zero
            `PWMDT_IDX_CTRL: rd_word = {8'h00, ctrl.dead_time_control_field, ctrl.compensation_polarity_bit, 2'b00,
                                        ctrl.alignment_select_bit, ctrl.external_reset_control_bit, ctrl.immediate_update_bit};
            `PWMDT_IDX_CFG: rd_word = {12'h000, cfg.use_mdc, cfg.current_limit_mode_bit, cfg.independent_time_base_option, cfg.en};
            `PWMDT_IDX_PERIOD: rd_word = period_buf;
            `PWMDT_IDX_MDUTY: rd_word = tim_buf.mdc;
            `PWMDT_IDX_GDUTY: rd_word = tim_buf.pdc;
            `PWMDT_IDX_DT: rd_word = tim_buf.dtr;
            `PWMDT_IDX_ALTDT: rd_word = tim_buf.alt;
            `PWMDT_IDX_PHASE: rd_word = tim_buf.phase;
            `PWMDT_IDX_STATUS: rd_word = tb;
            `PWMDT_IDX_ADUTY: rd_word = duty;
            default: rd_word = 16'h0000;
        endcase
    end

    // ****************************************
    // Register next values
    // ****************************************
    wire logic [5:0] ctrl_bits = {wdata_in[`PWMDT_DTC_HI:`PWMDT_DTC_LO],
                                  wdata_in[`PWMDT_COMPENSATION_POLARITY_BIT_BIT], wdata_in[`PWMDT_CAM_BIT],
                                  wdata_in[`PWMDT_EXTERNAL_RESET_CONTROL_BIT_BIT], wdata_in[`PWMDT_IUE_BIT]};
    wire logic [3:0] cfg_bits = {wdata_in[`PWMDT_EN_BIT], wdata_in[`PWMDT_ITB_BIT],
                                 wdata_in[`PWMDT_CURRENT_LIMIT_MODE_BIT_BIT], wdata_in[`PWMDT_USE_MDC_BIT]};
    wire pwmdt_ctrl_t next_ctrl = wr_ctrl ? pwmdt_ctrl_t'(ctrl_bits) : ctrl;
    wire pwmdt_cfg_t next_cfg = wr_cfg ? pwmdt_cfg_t'(cfg_bits) : cfg;
    wire logic [15:0] next_period_buf = wr_period ? wdata_in : period_buf;
    wire pwmdt_timing_t next_tim_buf = wr_timing ? tim_written : tim_buf;
    wire logic [15:0] next_period_act = boundary ? period_buf : period_act;
    wire logic next_pb = boundary && cfg.en;
    wire logic [15:0] next_rdata = rd_in ? rd_word : 16'h0000;

    // ****************************************
    // Control and configuration
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg <= '0;
        end else begin
            cfg <= next_cfg;
        end
    end

    // ****************************************
    // Buffered copies
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            period_buf <= `PWMDT_RST_PERIOD;
        end else begin
            period_buf <= next_period_buf;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tim_buf <= '0;
        end else begin
            tim_buf <= next_tim_buf;
        end
    end

    // ****************************************
    // Active copies
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            period_act <= `PWMDT_RST_PERIOD;
        end else begin
            period_act <= next_period_act;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tim_act <= '0;
        end else begin
            tim_act <= next_tim_act;
        end
    end

    // ****************************************
    // Time base and delay
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tb <= `PWMDT_RST_WORD;
            dir <= PWMDT_UP;
        end else begin
            tb <= next_tb;
            dir <= next_dir;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dly_cnt <= `PWMDT_RST_WORD;
            raw_prev <= 1'b0;
        end else begin
            dly_cnt <= next_dly;
            raw_prev <= raw;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cl_sync <= 2'b00;
            cmp_sync <= 2'b00;
            cl_prev <= 1'b0;
        end else begin
            cl_sync <= {cl_sync[0], curr_limit_in};
            cmp_sync <= {cmp_sync[0], compensation_input_in};
            cl_prev <= cl_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            high_side_output_out <= 1'b0;
            low_side_output_out <= 1'b0;
        end else begin
            high_side_output_out <= next_hi;
            low_side_output_out <= next_lo;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            period_boundary_out <= 1'b0;
            rdata_out <= 16'h0000;
        end else begin
            period_boundary_out <= next_pb;
            rdata_out <= next_rdata;
        end
    end

endmodule : pwmdt_core
`default_nettype wire

// ==== design/pwmdt_params.svh ====
// Offsets, field positions and reset values of the PWM generator control block.
// Assumes inclusion by the package, the design file and the checker.
`ifndef PWMDT_PARAMS_SVH
`define PWMDT_PARAMS_SVH

// ****************************************
// Register word indices
// ****************************************
`define PWMDT_ADDR_W 4
`define PWMDT_IDX_CTRL 4'h0
`define PWMDT_IDX_CFG 4'h1
`define PWMDT_IDX_PERIOD 4'h2
`define PWMDT_IDX_MDUTY 4'h3
`define PWMDT_IDX_GDUTY 4'h4
`define PWMDT_IDX_DT 4'h5
`define PWMDT_IDX_ALTDT 4'h6
`define PWMDT_IDX_PHASE 4'h7
`define PWMDT_IDX_STATUS 4'h8
`define PWMDT_IDX_ADUTY 4'h9

// ****************************************
// Control register fields
// ****************************************
`define PWMDT_DTC_HI 7
`define PWMDT_DTC_LO 6
`define PWMDT_COMPENSATION_POLARITY_BIT_BIT 5
`define PWMDT_CAM_BIT 2
`define PWMDT_EXTERNAL_RESET_CONTROL_BIT_BIT 1
`define PWMDT_IUE_BIT 0

// ****************************************
// Configuration register fields
// ****************************************
`define PWMDT_EN_BIT 0
`define PWMDT_ITB_BIT 1
`define PWMDT_CURRENT_LIMIT_MODE_BIT_BIT 2
`define PWMDT_USE_MDC_BIT 3

// ****************************************
// Reset values
// ****************************************
`define PWMDT_RST_PERIOD 16'h00ff
`define PWMDT_RST_WORD 16'h0000

`endif

// ==== design/pwmdt_pkg.sv ====
// Types shared by the PWM generator control block.
// Assumes the params header sits beside it in design/.
`include "pwmdt_params.svh"

package pwmdt_pkg;

    // ****************************************
    // Dead-time modes and time base direction
    // ****************************************
    typedef enum logic [1:0] {
        PWMDT_DT_POS = 2'h0,
        PWMDT_DT_NEG = 2'h1,
        PWMDT_DT_OFF = 2'h2,
        PWMDT_DT_COMP = 2'h3
    } pwmdt_dtmode_t;

    typedef enum logic {
        PWMDT_UP,
        PWMDT_DOWN
    } pwmdt_dir_t;

    // ****************************************
    // Control byte and timing word sets
    // ****************************************
    typedef struct packed {
        pwmdt_dtmode_t dead_time_control_field;
        logic compensation_polarity_bit;
        logic alignment_select_bit;
        logic external_reset_control_bit;
        logic immediate_update_bit;
    } pwmdt_ctrl_t;

    typedef struct packed {
        logic en;
        logic independent_time_base_option;
        logic current_limit_mode_bit;
        logic use_mdc;
    } pwmdt_cfg_t;

    typedef struct packed {
        logic [15:0] mdc;
        logic [15:0] pdc;
        logic [15:0] dtr;
        logic [15:0] alt;
        logic [15:0] phase;
    } pwmdt_timing_t;

endpackage : pwmdt_pkg

// ==== test/pwmdt_core_chk.sv ====
// Port assertions for the PWM generator block.
// Assumes a bind onto pwmdt_core.
`timescale 1ns/1ps
`default_nettype none
`include "pwmdt_params.svh"
module pwmdt_core_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Register port
    input wire logic [`PWMDT_ADDR_W-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    // Pins
    input wire logic curr_limit_in,
    input wire logic compensation_input_in,
    input wire logic high_side_output_out,
    input wire logic low_side_output_out,
    input wire logic period_boundary_out
);
    logic [7:0] ctl;
    logic [3:0] cfg;
    wire logic h = high_side_output_out;
    wire logic l = low_side_output_out;
    wire logic en = cfg[0];
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl <= 8'h00;
            cfg <= 4'h0;
        end else if (wr_in && addr_in == `PWMDT_IDX_CTRL) begin
            ctl <= wdata_in[7:0];
        end else if (wr_in && addr_in == `PWMDT_IDX_CFG) begin
            cfg <= wdata_in[3:0];
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    ctrl_read_a: assert property ($past(rd_in) && $past(addr_in) == `PWMDT_IDX_CTRL
        |-> rdata_out == {8'h00, ctl & 8'he7}) else $error("control readback");
    off_pair_a: assert property ((en && ctl[7:6] == 2'h2) [*3] |-> h != l)
        else $error("off mode pair");
    pos_gap_a: assert property ((en && ctl[7:6] == 2'h0) [*3] |-> !(h && l))
        else $error("positive overlap");
    pos_dead_a: assert property ((en && ctl[7:6] == 2'h0) [*3] ##0 $rose(h)
        |-> !$past(l) && !$past(l, 2)) else $error("positive dead time");
    neg_overlap_a: assert property ((en && ctl[7:6] == 2'h1) [*4] |-> h || l)
        else $error("negative gap");
    comp_pair_a: assert property ((en && ctl[7:6] == 2'h3) [*4] |-> h != l)
        else $error("compensation pair");
    duty_now_a: assert property (wr_in && addr_in == `PWMDT_IDX_GDUTY && ctl[0] && !cfg[3]
        ##2 rd_in && addr_in == `PWMDT_IDX_ADUTY |=> rdata_out == $past(wdata_in, 3))
        else $error("duty not immediate");
    ext_reset_a: assert property ($rose(curr_limit_in) && ctl[1] && cfg[1] && en
        ##[3:8] rd_in && addr_in == `PWMDT_IDX_STATUS |=> rdata_out < 16'h0008)
        else $error("time base not reset");
    edge_pulse_a: assert property (period_boundary_out |=> !period_boundary_out)
        else $error("boundary pulse long");
    cover property (en && ctl[7:6] == 2'h3 && h);
    cover property (en && cfg[1] && ctl[2] && period_boundary_out);
    cover property (wr_in && ctl[0]);
endmodule : pwmdt_core_chk
bind pwmdt_core pwmdt_core_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .curr_limit_in(curr_limit_in),
    .compensation_input_in(compensation_input_in),
    .high_side_output_out(high_side_output_out),
    .low_side_output_out(low_side_output_out), .period_boundary_out(period_boundary_out));
`default_nettype wire

// ==== test/pwmdt_switch_model.sv ====
// Power stage model: on-time counts per period, sense pins.
// Assumes gate drives and boundary pulse on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module pwmdt_switch_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Gate drives
    input wire logic hi_in,
    input wire logic lo_in,
    input wire logic pb_in,
    // Bench requests
    input wire logic comp_sel_in,
    input wire logic trip_in,
    // Sense pins and counts
    output logic curr_limit_out,
    output logic comp_out,
    output int hi_cnt_out,
    output int lo_cnt_out,
    output logic overlap_out
);
    int hc, lc, tk;
    logic ov;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {hc, lc, tk, hi_cnt_out, lo_cnt_out} <= '0;
            {ov, overlap_out, curr_limit_out, comp_out} <= '0;
        end else begin
            comp_out <= comp_sel_in;
            tk <= trip_in ? 4 : (tk > 0 ? tk - 1 : 0);
            curr_limit_out <= tk > 0;
            hc <= pb_in ? int'(hi_in) : hc + int'(hi_in);
            lc <= pb_in ? int'(lo_in) : lc + int'(lo_in);
            ov <= pb_in ? hi_in && lo_in : ov || (hi_in && lo_in);
            if (pb_in) begin
                hi_cnt_out <= hc;
                lo_cnt_out <= lc;
                overlap_out <= ov;
            end
        end
    end
endmodule : pwmdt_switch_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Bench for the PWM generator block.
// Assumes design, model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic csel = 1'b0;
    logic trip = 1'b0;
    wire logic [15:0] rdata;
    wire logic hi, lo, pb, cl, cmp;
    int hcnt, lcnt, n_mismatch, compares, cyc, i;
    int seed = 12;
    logic ovl;
    logic [15:0] v, d;
    int mdl [0:15] = '{2: 255, default: 0};
    always #20 clk = ~clk;
    pwmdt_core dut (.clk_in(clk), .arst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .curr_limit_in(cl),
        .compensation_input_in(cmp), .high_side_output_out(hi),
        .low_side_output_out(lo), .period_boundary_out(pb));
    pwmdt_switch_model sw (.clk_in(clk), .arst_n_in(rst_n), .hi_in(hi), .lo_in(lo),
        .pb_in(pb), .comp_sel_in(csel), .trip_in(trip), .curr_limit_out(cl),
        .comp_out(cmp), .hi_cnt_out(hcnt), .lo_cnt_out(lcnt), .overlap_out(ovl));
    task automatic check(input string s, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] dv);
        if (w && a < 4'h8) begin
            mdl[a] = int'(dv) & (a == 4'h0 ? 32'h00e7 : (a == 4'h1 ? 32'h000f : 32'hffff));
        end
        @(posedge clk);
        addr <= a;
        wdata <= dv;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 v = rdata;
    endtask : acc
    task automatic run(input logic [15:0] c, input logic [3:0] g);
        acc(1'b1, 4'h1, 16'h0000);
        acc(1'b1, 4'h0, c);
        acc(1'b1, 4'h1, {12'h000, g});
        repeat (3) @(posedge clk iff pb);
        #1;
    endtask : run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b1, 4'ha, 16'h1234);
        for (i = 0; i < 11; i++) begin
            acc(1'b0, i[3:0], 16'h0000);
            check("reset value", v, (i == 2) ? 16'h00ff : 16'h0000);
        end
        acc(1'b1, 4'h8, 16'hffff);
        acc(1'b0, 4'h8, 16'h0000);
        check("status write", v, 16'h0000);
        acc(1'b1, 4'h0, 16'hffff);
        acc(1'b0, 4'h0, 16'h0000);
        check("control", v, 16'h00e7);
        acc(1'b1, 4'h2, 16'h0009);
        acc(1'b1, 4'h4, 16'h0005);
        acc(1'b1, 4'h5, 16'h0002);
        acc(1'b1, 4'h6, 16'h0002);
        for (i = 0; i < 8; i++) begin
            acc(1'b0, i[3:0], 16'h0000);
            check("readback", v, 16'(mdl[i]));
        end
        for (i = 0; i < 3; i++) begin
            run(i == 0 ? 16'h0080 : 16'h0084, i == 1 ? 4'h3 : 4'h1);
            check("high count", 16'(hcnt), i == 1 ? 16'h0009 : 16'h0005);
            check("period", 16'(hcnt + lcnt), i == 1 ? 16'h0012 : 16'h000a);
        end
        for (i = 0; i < 3; i++) begin
            run(i == 2 ? 16'h0040 : (i == 1 ? 16'h0020 : 16'h0000), 4'h1);
            check("overlap", {15'h0000, ovl}, i == 2 ? 16'h0001 : 16'h0000);
            check("balance", 16'(hcnt == lcnt), 16'h0001);
        end
        for (i = 0; i < 4; i++) begin
            csel <= i[0];
            run(16'h00c0 | {10'h000, i[1], 5'h00}, 4'h1);
            check("high shortened", 16'(hcnt < lcnt), 16'(i[1] == i[0]));
        end
        for (i = 0; i < 2; i++) begin
            run(16'h0080 | 16'(i), 4'h1);
            d = 16'h0001 + 16'($unsigned($random(seed)) % 8);
            acc(1'b1, 4'h4, d);
            acc(1'b0, 4'h9, 16'h0000);
            check("duty now", v, i == 1 ? d : 16'h0005);
            @(posedge clk iff pb);
            acc(1'b0, 4'h9, 16'h0000);
            check("duty after", v, d);
            acc(1'b1, 4'h4, 16'h0005);
        end
        acc(1'b1, 4'h3, 16'h0003);
        acc(1'b1, 4'h1, 16'h0009);
        acc(1'b0, 4'h9, 16'h0000);
        check("master duty", v, 16'h0003);
        acc(1'b1, 4'h2, 16'h00ff);
        for (i = 0; i < 2; i++) begin
            // time base on, limit mode off
            run(16'h0080 | {14'h0000, i[0], 1'b0}, 4'h3);
            repeat (40) @(posedge clk);
            trip <= 1'b1;
            @(posedge clk);
            trip <= 1'b0;
            repeat (4) @(posedge clk);
            acc(1'b0, 4'h8, 16'h0000);
            check("time base cleared", 16'(v < 16'h0008), 16'(i));
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
